// ---- pkg/nvs_params.svh ----
// Constants for the data EEPROM erase and program sequencer.
// Summary of operation
// - 0x4044 selects single-word erase.
// - 0x4004 programs one word from latch.
// - 0x400A programs sixteen-word block from latches.
// - Start needs key 0x55 then 0xAA first.
// - Start refused unless write enable already set.
// - Hardware never clears enable; clearing never aborts.
// - Completion clears start and sets complete flag.
// - Complete flag holds until software clears it.
// - Cycle is self-timed, about 2 ms, CPU runs.
// - Address register captures last table write address.
// - Enable clear at power-up; no write during timer.
// - Software writes of zero to start ignored.
// - Non-power-on reset during cycle sets error, keeps address.
// - Reads during a cycle return unspecified data.
`ifndef NVS_PARAMS_SVH
`define NVS_PARAMS_SVH
`define NVS_OP_WORD_ERASE 16'h4044
`define NVS_OP_WORD_PROG 16'h4004
`define NVS_OP_BLOCK_PROG 16'h400A
`define NVS_KEY_FIRST 8'h55
`define NVS_KEY_SECOND 8'hAA
`define NVS_BIT_START 15
`define NVS_BIT_WRITE_ENABLE_BIT 14
`define NVS_BIT_WRITE_ERROR_BIT 13
`define NVS_CTRL_RESET 16'h0000
`define NVS_LATCH_COUNT 16
`define NVS_CYCLE_TIME_NS 2000000
`define NVS_CLK_PERIOD_NS 50
`define NVS_CYCLE_COUNT (`NVS_CYCLE_TIME_NS / `NVS_CLK_PERIOD_NS)
`endif

// ---- pkg/nvs_pkg.sv ----
// Types shared by the data EEPROM sequencer.
package nvs_pkg;
  typedef enum logic [1:0] {
    NVS_KEY_IDLE = 2'b00,
    NVS_KEY_GOT1 = 2'b01,
    NVS_KEY_OPEN = 2'b10
  } nvs_key_state_t;

  typedef enum logic [1:0] {
    NVS_OP_NONE = 2'b00,
    NVS_OP_ERASE = 2'b01,
    NVS_OP_PROG1 = 2'b10,
    NVS_OP_PROG16 = 2'b11
  } nvs_op_t;

  // One request towards the array.
  typedef struct packed {
    logic valid;
    nvs_op_t op;
    logic [23:0] addr;
  } nvs_array_req_t;

  // Table write from the core.
  typedef struct packed {
    logic valid;
    logic [7:0] page;
    logic [15:0] offset;
    logic [15:0] data;
  } nvs_table_wr_t;
endpackage : nvs_pkg

// ---- src/nvs_cycle_timer.sv ----
// Self-timed cycle counter for erase and program cycles.
`include "nvs_params.svh"
module nvs_cycle_timer #(
  parameter int unsigned CYCLES = `NVS_CYCLE_COUNT
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_resetn, // Synchronous reset, active low.
  input wire logic i_start, // Pulse that starts a cycle.
  output logic o_busy, // Cycle running.
  output logic o_done // One-cycle pulse at the end.
);
  logic [31:0] count;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      count <= 32'h0000_0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        count <= CYCLES - 1;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (count == 32'h0000_0000) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count <= count - 32'h0000_0001;
        end
      end
    end
  end
endmodule : nvs_cycle_timer

// ---- src/nvs_sequencer.sv ----
// Data EEPROM erase and program sequencer with unlock key and latches.
`include "nvs_params.svh"
module nvs_sequencer #(
  parameter int unsigned CYCLE_COUNT = `NVS_CYCLE_COUNT
) (
  input wire logic i_clk_sys, // System clock, 20 MHz.
  input wire logic i_resetn, // Synchronous reset, active low.
  input wire logic i_por, // High for power-on reset cause.
  input wire logic i_pwrup_timer, // Power-up timer still running.
  input wire logic i_ctrl_wr, // Write strobe of control register.
  input wire logic [15:0] i_ctrl_wdata, // Data written to control register.
  input wire logic i_key_wr, // Write strobe of key register.
  input wire logic [7:0] i_key_wdata, // Data written to key register.
  input wire logic i_adrl_wr, // Write strobe of low address register.
  input wire logic i_adrh_wr, // Write strobe of high address register.
  input wire logic [15:0] i_adr_wdata, // Data for address registers.
  input wire logic i_other_wr, // Any other register write by the core.
  input wire nvs_pkg::nvs_table_wr_t i_tblwr, // Table write access.
  input wire logic i_flag_clr, // Software clears completion flag.
  input wire logic i_array_busy, // Array still busy; informative.
  output logic [15:0] o_nv_control_reg, // Control register read value.
  output logic [23:0] o_nv_address, // Address registers read value.
  output logic o_write_complete_flag, // Sticky completion flag.
  output logic o_cycle_busy, // Cycle in progress; reads unreliable.
  output nvs_pkg::nvs_array_req_t o_array_req, // Operation to the array.
  output logic [255:0] o_latch_data // Sixteen write latches.
);
  logic start_bit;
  logic write_enable_bit;
  logic write_error_bit;
  logic [6:0] op_select;
  logic [15:0] nv_address_low_reg;
  logic [7:0] nv_address_high_reg;
  logic [15:0] latches [0:`NVS_LATCH_COUNT-1];
  nvs_pkg::nvs_key_state_t key_state;
  logic launch;
  logic timer_busy;
  logic timer_done;
  logic in_cycle;

  // Map the control value to an operation; bits 15:14 are read as 01.
  function automatic nvs_pkg::nvs_op_t decode_op(input logic [15:0] v);
    logic [15:0] m;
    m = {2'b01, v[13:0]};
    if (m == `NVS_OP_WORD_ERASE) begin
      decode_op = nvs_pkg::NVS_OP_ERASE;
    end else if (m == `NVS_OP_WORD_PROG) begin
      decode_op = nvs_pkg::NVS_OP_PROG1;
    end else if (m == `NVS_OP_BLOCK_PROG) begin
      decode_op = nvs_pkg::NVS_OP_PROG16;
    end else begin
      decode_op = nvs_pkg::NVS_OP_NONE;
    end
  endfunction : decode_op

  // Start only from the unlocked key state with enable already stored;
  // the enable seen is the old one, so one write cannot set both.
  assign launch = i_ctrl_wr && i_ctrl_wdata[`NVS_BIT_START] && !start_bit
    && write_enable_bit
    && key_state == nvs_pkg::NVS_KEY_OPEN
    && !i_pwrup_timer;

  assign in_cycle = start_bit;

  nvs_cycle_timer #(
    .CYCLES(CYCLE_COUNT)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_start(launch),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // Unlock key state machine.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      key_state <= nvs_pkg::NVS_KEY_IDLE;
    end else if (i_key_wr) begin
      unique case (key_state)
        nvs_pkg::NVS_KEY_IDLE, nvs_pkg::NVS_KEY_OPEN: begin
          key_state <= (i_key_wdata == `NVS_KEY_FIRST) ?
            nvs_pkg::NVS_KEY_GOT1 : nvs_pkg::NVS_KEY_IDLE;
        end
        nvs_pkg::NVS_KEY_GOT1: begin
          if (i_key_wdata == `NVS_KEY_SECOND) begin
            key_state <= nvs_pkg::NVS_KEY_OPEN;
          end else if (i_key_wdata == `NVS_KEY_FIRST) begin
            key_state <= nvs_pkg::NVS_KEY_GOT1;
          end else begin
            key_state <= nvs_pkg::NVS_KEY_IDLE;
          end
        end
        default: begin
          key_state <= nvs_pkg::NVS_KEY_IDLE;
        end
      endcase
    end else if (i_ctrl_wr || i_adrl_wr || i_adrh_wr || i_other_wr
        || i_tblwr.valid) begin
      key_state <= nvs_pkg::NVS_KEY_IDLE;
    end
  end

  // Control register bits.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      start_bit <= 1'b0;
      write_enable_bit <= 1'b0;
      op_select <= 7'h00;
    end else begin
      if (timer_done) begin
        start_bit <= 1'b0;
      end else if (launch) begin
        start_bit <= 1'b1;
      end
      // Zero written to start is ignored; only completion clears it.
      if (i_ctrl_wr) begin
        write_enable_bit <= i_ctrl_wdata[`NVS_BIT_WRITE_ENABLE_BIT];
        if (!in_cycle) begin
          op_select <= {i_ctrl_wdata[6], i_ctrl_wdata[5:0]};
        end
      end
    end
  end

  // Error bit: set when a non-power-on reset cuts a running cycle.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      if (i_por) begin
        write_error_bit <= 1'b0;
      end else if (start_bit) begin
        write_error_bit <= 1'b1;
      end
    end else if (launch) begin
      write_error_bit <= 1'b0;
    end
  end

  // Address registers survive a non-power-on reset unchanged.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn && i_por) begin
      nv_address_low_reg <= 16'h0000;
      nv_address_high_reg <= 8'h00;
    end else if (i_resetn) begin
      if (i_tblwr.valid) begin
        nv_address_low_reg <= i_tblwr.offset;
        nv_address_high_reg <= i_tblwr.page;
      end else if (!in_cycle) begin
        if (i_adrl_wr) begin
          nv_address_low_reg <= i_adr_wdata;
        end
        if (i_adrh_wr) begin
          nv_address_high_reg <= i_adr_wdata[7:0];
        end
      end
    end
  end

  // Write latches, indexed by the low word address bits.
  always_ff @(posedge i_clk_sys) begin
    if (i_tblwr.valid && !in_cycle) begin
      latches[i_tblwr.offset[4:1]] <= i_tblwr.data;
    end
  end

  // Sticky completion flag; a set in the clearing cycle wins.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_write_complete_flag <= 1'b0;
    end else if (timer_done) begin
      o_write_complete_flag <= 1'b1;
    end else if (i_flag_clr) begin
      o_write_complete_flag <= 1'b0;
    end
  end

  // Register views for the core; they trail the internal state by one edge.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_nv_control_reg <= `NVS_CTRL_RESET;
      o_nv_address <= 24'h000000;
    end else begin
      o_nv_control_reg <= {start_bit, write_enable_bit, write_error_bit,
        6'h00, op_select};
      o_nv_address <= {nv_address_high_reg, nv_address_low_reg};
    end
  end

  // Busy view for the core: reads are unreliable while this is high.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_cycle_busy <= 1'b0;
    end else begin
      o_cycle_busy <= start_bit || timer_busy;
    end
  end

  // The request pulses on the launch edge; operation and address then
  // stay put, so later table writes cannot move a running cycle.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_array_req <= '0;
    end else begin
      o_array_req.valid <= launch;
      if (launch) begin
        o_array_req.op <= decode_op({2'b01, 7'h00, op_select});
        o_array_req.addr <= {nv_address_high_reg, nv_address_low_reg};
      end
    end
  end

  // Latch contents as the array sees them.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_latch_data <= 256'h0;
    end else begin
      for (int i = 0; i < `NVS_LATCH_COUNT; i++) begin
        o_latch_data[i*16 +: 16] <= latches[i];
      end
    end
  end
endmodule : nvs_sequencer

// ---- sim/nvs_sequencer_monitor.sv ----
// Port-level assertions for the data EEPROM sequencer.
module nvs_sequencer_monitor #(
  parameter int unsigned CYCLE_COUNT = 8
) (
  input wire logic i_clk_sys, // Clock.
  input wire logic i_resetn, // Reset, active low.
  input wire logic i_pwrup_timer, // Power-up timer.
  input wire logic i_ctrl_wr, // Control write strobe.
  input wire logic [15:0] i_ctrl_wdata, // Control write data.
  input wire logic i_flag_clr, // Flag clear.
  input wire logic [15:0] o_nv_control_reg, // Control register.
  input wire logic o_write_complete_flag, // Completion flag.
  input wire logic o_cycle_busy, // Cycle running.
  input wire nvs_pkg::nvs_array_req_t o_array_req // Array request.
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIM = CYCLE_COUNT + 4;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  sequence start_write_s;
    $past(i_ctrl_wr, 2) && $past(i_ctrl_wdata[15], 2);
  endsequence
  sequence busy_run_s;
    o_cycle_busy [*4] ##[1:LIM] !o_cycle_busy;
  endsequence
  start_after_write_a: assert property (
    $rose(o_nv_control_reg[15]) |-> start_write_s)
    else $error("start without write");
  no_pwrup_start_a: assert property (
    $rose(o_nv_control_reg[15]) |-> !$past(i_pwrup_timer, 2))
    else $error("start in power-up");
  end_sets_flag_a: assert property (
    $fell(o_nv_control_reg[15]) |-> ##[0:1] o_write_complete_flag)
    else $error("end without flag");
  flag_sticky_a: assert property (
    o_write_complete_flag && !i_flag_clr && !$past(i_flag_clr)
    |=> o_write_complete_flag)
    else $error("flag lost");
  cycle_length_a: assert property (
    $rose(o_cycle_busy) |-> busy_run_s)
    else $error("bad cycle length");
  req_pulse_a: assert property (
    o_array_req.valid |=> !o_array_req.valid)
    else $error("request too long");
  req_on_start_a: assert property (
    $rose(o_nv_control_reg[15]) |-> $past(o_array_req.valid))
    else $error("no request");
  enable_kept_a: assert property (
    $fell(o_nv_control_reg[14])
    |-> ($past(i_ctrl_wr) && !$past(i_ctrl_wdata[14]))
    || ($past(i_ctrl_wr, 2) && !$past(i_ctrl_wdata[14], 2)))
    else $error("enable cleared");
endmodule : nvs_sequencer_monitor

bind nvs_sequencer nvs_sequencer_monitor #(.CYCLE_COUNT(CYCLE_COUNT)) u_mon (
  .i_clk_sys, .i_resetn, .i_pwrup_timer, .i_ctrl_wr, .i_ctrl_wdata,
  .i_flag_clr, .o_nv_control_reg, .o_write_complete_flag, .o_cycle_busy,
  .o_array_req);

// ---- sim/nvs_core_model.sv ----
// Behavioural core issuing register and table writes.
module nvs_core_model (
  input wire logic i_clk_sys, // Clock.
  output logic [5:0] o_wr, // Strobes: ctrl,key,adrl,adrh,other,flag.
  output logic [15:0] o_wdata, // Shared write data.
  output nvs_pkg::nvs_table_wr_t o_tblwr // Table write.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr = 6'h00;
    o_wdata = 16'h0000;
    o_tblwr = '0;
  end
  // Data turns over on release so a stale value can never be taken.
  task acc(input int k, input logic [15:0] d);
    @(negedge i_clk_sys);
    o_wdata = d;
    o_wr = 6'h01 << k;
    @(negedge i_clk_sys);
    o_wr = 6'h00;
    o_wdata = ~d;
  endtask : acc
  task tbl(input logic [7:0] pg, input logic [15:0] off, input logic [15:0] d);
    @(negedge i_clk_sys);
    o_tblwr = {1'b1, pg, off, d};
    @(negedge i_clk_sys);
    o_tblwr = {1'b0, ~pg, ~off, ~d};
  endtask : tbl
endmodule : nvs_core_model

// ---- sim/test_nvs_sequencer.sv ----
// Self-checking bench for the data EEPROM sequencer.
module test_nvs_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CYC = 8;
  logic i_clk_sys, i_resetn, i_por, i_pwrup_timer, flag, busy;
  logic [5:0] wr;
  logic [15:0] wd, ctrl;
  logic [23:0] adr;
  logic [255:0] lat;
  nvs_pkg::nvs_table_wr_t tw;
  nvs_pkg::nvs_array_req_t req, last_req;
  int error_cnt = 0;
  int check_count = 0;
  int req_cnt = 0;
  initial begin
    i_clk_sys = 0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  nvs_core_model core (.i_clk_sys(i_clk_sys), .o_wr(wr), .o_wdata(wd),
    .o_tblwr(tw));
  nvs_sequencer #(.CYCLE_COUNT(CYC)) dut (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .i_por(i_por), .i_pwrup_timer(i_pwrup_timer),
    .i_ctrl_wr(wr[0]), .i_ctrl_wdata(wd), .i_key_wr(wr[1]),
    .i_key_wdata(wd[7:0]), .i_adrl_wr(wr[2]), .i_adrh_wr(wr[3]),
    .i_adr_wdata(wd), .i_other_wr(wr[4]), .i_tblwr(tw), .i_flag_clr(wr[5]),
    .i_array_busy(1'b0), .o_nv_control_reg(ctrl), .o_nv_address(adr),
    .o_write_complete_flag(flag), .o_cycle_busy(busy), .o_array_req(req),
    .o_latch_data(lat));
  always @(negedge i_clk_sys) if (req.valid === 1'b1) begin
    req_cnt++;
    last_req = req;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task tally_and_finish;
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task unlock;
    core.acc(1, 16'h0055);
    core.acc(1, 16'h00AA);
  endtask : unlock
  task none(input int n);
    repeat (4) @(negedge i_clk_sys);
    chk(ctrl[15], 0);
    chk(req_cnt, n);
  endtask : none
  task run(input logic [15:0] op, input nvs_pkg::nvs_op_t e,
    input logic [23:0] a, input bit meddle);
    int n;
    int w;
    n = req_cnt;
    core.acc(0, op);
    unlock;
    core.acc(0, op | 16'h8000);
    repeat (2) @(negedge i_clk_sys);
    w = 2;
    chk(busy, 1);
    if (meddle) begin
      core.acc(0, 16'h0044);
      @(negedge i_clk_sys);
      w = 5;
      chk(ctrl[15], 1);
    end
    // Negedges are counted from the one after the start write.
    while (w < 40 && flag !== 1'b1) begin
      @(negedge i_clk_sys);
      w++;
    end
    chk(w, CYC + 1);
    chk(flag, 1);
    @(negedge i_clk_sys);
    chk(ctrl[15], 0);
    chk(busy, 0);
    chk(ctrl[14], !meddle);
    chk(req_cnt, n + 1);
    chk(last_req.op, e);
    chk(last_req.addr, a);
    repeat (3) @(negedge i_clk_sys);
    chk(flag, 1);
    core.acc(5, 16'h0000);
    chk(flag, 0);
  endtask : run
  initial begin
    i_resetn = 0;
    i_por = 1;
    i_pwrup_timer = 0;
    repeat (5) @(negedge i_clk_sys);
    i_resetn = 1;
    i_por = 0;
    chk(ctrl, 0);
    core.acc(0, 16'h4044);
    core.acc(0, 16'hC044);
    none(0);
    core.acc(1, 16'h00AA);
    core.acc(1, 16'h0055);
    core.acc(0, 16'hC044);
    none(0);
    core.acc(1, 16'h0055);
    core.acc(4, 16'h0000);
    core.acc(1, 16'h00AA);
    core.acc(0, 16'hC044);
    none(0);
    core.acc(0, 16'h0044);
    unlock;
    core.acc(0, 16'hC044);
    none(0);
    i_pwrup_timer = 1;
    core.acc(0, 16'h4044);
    unlock;
    core.acc(0, 16'hC044);
    none(0);
    i_pwrup_timer = 0;
    core.acc(3, 16'h007F);
    core.acc(2, 16'hF010);
    @(negedge i_clk_sys);
    chk(adr, 24'h7FF010);
    run(16'h4044, nvs_pkg::NVS_OP_ERASE, 24'h7FF010, 0);
    core.tbl(8'h7F, 16'hF012, 16'hA55A);
    @(negedge i_clk_sys);
    chk(lat[144+:16], 16'hA55A);
    run(16'h4004, nvs_pkg::NVS_OP_PROG1, 24'h7FF012, 0);
    for (int i = 0; i < 16; i++) core.tbl(8'h7F, 16'(16'hF000 + 2 * i),
      16'(16'h1000 + i));
    @(negedge i_clk_sys);
    for (int i = 0; i < 16; i++) begin
      chk(lat[i*16+:16], 16'h1000 + i);
    end
    run(16'h400A, nvs_pkg::NVS_OP_PROG16, 24'h7FF01E, 0);
    run(16'h4044, nvs_pkg::NVS_OP_ERASE, 24'h7FF01E, 1);
    core.acc(0, 16'h4044);
    unlock;
    core.acc(0, 16'hC044);
    repeat (3) @(negedge i_clk_sys);
    i_resetn = 0;
    repeat (2) @(negedge i_clk_sys);
    i_resetn = 1;
    @(negedge i_clk_sys);
    chk(ctrl[13], 1);
    chk(adr, 24'h7FF01E);
    tally_and_finish;
  end
  // Whole run needs well under 500 cycles; this only catches a hang.
  initial begin
    repeat (2000) @(posedge i_clk_sys);
    error_cnt++;
    tally_and_finish;
  end
endmodule : test_nvs_sequencer
